//--- core/asr_map.svh
// Purpose: Constants for the asynchronous SRAM module host controller
// Assumes: 50 MHz clk; figures are fixed for the -20 grade, ASR_GRADE_NS selects nothing
// Notes: Times in ns, cycle counts derived by rounding up
// Function
// RULE1 - Host holds write strobe high during reads
// RULE2 - Read data valid after address access time
// RULE3 - Read data valid after output enable time
// RULE4 - Device drivers turn on no earlier than stated
// RULE5 - Device drivers float within 7 ns
// RULE6 - Previous read data held 3 ns
// RULE7 - Device enters standby after deselect
// RULE8 - Strobe or select high on address change
// RULE9 - Write only during select and strobe overlap
// RULE10 - Select asserted long enough before write end
// RULE11 - Address valid long before write end
// RULE12 - Address held for write recovery
// RULE13 - Write data set up, held after end
// RULE14 - Device drivers off after strobe falls
// RULE15 - Late select keeps outputs floating in write
// RULE16 - Stretch strobe when output enable low
// RULE17 - Device drives no sooner than write end
// RULE18 - Four active-low byte lane selects
// RULE19 - 1M words of 32 bits, 20 address lines
// RULE20 - Device drives only on read combination
// RULE21 - Host rounds minimum times up to cycles
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_CLK_PERIOD_NS 20
`define ASR_GRADE_NS 20
// -20 grade figures
`define ASR_READ_CYCLE_NS 20
`define ASR_ADDRESS_ACCESS_MAX_NS 20
`define ASR_OE_ACCESS_NS 10
`define ASR_OE_FLOAT_NS 7
`define ASR_WRITE_PULSE_MIN_NS 15
`define ASR_WRITE_CYCLE_NS 20
`define ASR_WRITE_RECOVERY_MIN_NS 3
`define ASR_DATA_OVERLAP_MIN_NS 12
`define ASR_WRITE_TO_FLOAT_MAX_NS 7
`define ASR_CEIL(t) (((t) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define ASR_RD_CYC `ASR_MAX(1, `ASR_CEIL(`ASR_MAX(`ASR_READ_CYCLE_NS, `ASR_ADDRESS_ACCESS_MAX_NS)))
`define ASR_WR_CYC `ASR_MAX(1, `ASR_CEIL(`ASR_MAX(`ASR_WRITE_PULSE_MIN_NS, \
	`ASR_WRITE_TO_FLOAT_MAX_NS + `ASR_DATA_OVERLAP_MIN_NS)))
`define ASR_REC_CYC `ASR_MAX(1, `ASR_CEIL(`ASR_MAX(`ASR_WRITE_RECOVERY_MIN_NS, `ASR_OE_FLOAT_NS)))
`endif

//--- core/asr_pkg.sv
// Purpose: Types for the SRAM module host controller
// Assumes: 20-bit word address, 32-bit data, four byte lanes
// Notes: None
package asr_pkg;
	typedef struct packed {
		logic write;
		logic [19:0] addr;
		logic [3:0] lanes;
		logic [31:0] wdata;
	} asr_req_s;
	typedef enum {ASR_IDLE, ASR_READ, ASR_WRITE, ASR_RECOVER} asr_state_e;
endpackage

//--- core/asr_host.sv
// Purpose: Host controller driving an asynchronous 1M x 32 SRAM module
// Assumes: Single 50 MHz clock; pins are registered outputs
// Notes: Address moves only on an edge where select and strobe were high
`include "asr_map.svh"
module asr_host #(
	parameter int RD_CYC = `ASR_RD_CYC,
	parameter int WR_CYC = `ASR_WR_CYC,
	parameter int REC_CYC = `ASR_REC_CYC
) (
	input wire logic clk, // Clock
	input wire logic rst, // Async reset, high
	input wire logic req_valid, // Request offered
	output logic req_ready, // Request taken
	input asr_pkg::asr_req_s req, // Request body
	output logic rsp_valid, // Read data pulse
	output logic [31:0] rsp_data, // Read data
	output logic [19:0] mem_addr, // Address pins
	output logic [3:0] mem_sel_n, // Byte lane selects
	output logic mem_we_n, // Write strobe
	output logic mem_oe_n, // Output enable
	output logic [31:0] mem_dq_o, // Data out
	output logic mem_dq_oe, // Data drive enable
	input wire logic [31:0] mem_dq_i // Data in
);
	import asr_pkg::*;
	// Reads add two sync cycles, so their count must still fit eight bits
	if (RD_CYC < 1 || WR_CYC < 1 || REC_CYC < 1 || RD_CYC > 253 || WR_CYC > 255
		|| REC_CYC > 255) begin : g_bad_counts
		$error("asr_host: cycle counts out of range");
	end
	// ----------------------------------------
	// Pin input sync
	// ----------------------------------------
	// Bus is asynchronous to clk; only the second stage is read
	logic [31:0] dq_s1_r, dq_s2_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_s1_r <= 32'h0;
			dq_s2_r <= 32'h0;
		end else begin
			dq_s1_r <= mem_dq_i;
			dq_s2_r <= dq_s1_r;
		end
	end
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Reads wait two extra cycles for the synchroniser
	localparam int RD_TOTAL = RD_CYC + 2;
	asr_state_e st_r, st_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [19:0] addr_r, addr_nxt;
	logic [3:0] sel_n_r, sel_n_nxt;
	logic we_n_r, we_n_nxt, oe_n_r, oe_n_nxt, dq_oe_r, dq_oe_nxt;
	logic [31:0] dq_o_r, dq_o_nxt, rd_r, rd_nxt;
	logic rv_r, rv_nxt;
	assign req_ready = (st_r == ASR_IDLE);
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		addr_nxt = addr_r;
		sel_n_nxt = sel_n_r;
		we_n_nxt = we_n_r;
		oe_n_nxt = oe_n_r;
		dq_oe_nxt = dq_oe_r;
		dq_o_nxt = dq_o_r;
		rd_nxt = rd_r;
		rv_nxt = 1'b0;
		case (st_r)
			ASR_IDLE: begin
				if (req_valid) begin
					addr_nxt = req.addr; // RULE8 RULE11
					sel_n_nxt = ~req.lanes; // RULE18
					if (req.write) begin
						// Strobe falls with select; OE stays high so no bus fight
						we_n_nxt = 1'b0; // RULE9
						oe_n_nxt = 1'b1; // RULE16
						dq_oe_nxt = 1'b1;
						dq_o_nxt = req.wdata; // RULE13
						cnt_nxt = 8'(WR_CYC); // RULE21
						st_nxt = ASR_WRITE;
					end else begin
						we_n_nxt = 1'b1; // RULE1
						oe_n_nxt = 1'b0;
						cnt_nxt = 8'(RD_TOTAL); // RULE2 RULE3
						st_nxt = ASR_READ;
					end
				end
			end
			ASR_READ: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					rd_nxt = dq_s2_r;
					rv_nxt = 1'b1;
					sel_n_nxt = 4'hF;
					oe_n_nxt = 1'b1; // RULE5
					cnt_nxt = 8'(REC_CYC);
					st_nxt = ASR_RECOVER;
				end
			end
			ASR_WRITE: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					// End write on both; address and data held one more period
					we_n_nxt = 1'b1; // RULE12
					sel_n_nxt = 4'hF; // RULE10
					cnt_nxt = 8'(REC_CYC);
					st_nxt = ASR_RECOVER;
				end
			end
			ASR_RECOVER: begin
				// Data released a period after the strobe rises: hold met with margin
				dq_oe_nxt = 1'b0; // RULE13 RULE17
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01)
					st_nxt = ASR_IDLE;
			end
			default: st_nxt = ASR_IDLE;
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= ASR_IDLE;
			cnt_r <= 8'h00;
			addr_r <= 20'h0;
			sel_n_r <= 4'hF;
			we_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			dq_oe_r <= 1'b0;
			dq_o_r <= 32'h0;
			rd_r <= 32'h0;
			rv_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			addr_r <= addr_nxt;
			sel_n_r <= sel_n_nxt;
			we_n_r <= we_n_nxt;
			oe_n_r <= oe_n_nxt;
			dq_oe_r <= dq_oe_nxt;
			dq_o_r <= dq_o_nxt;
			rd_r <= rd_nxt;
			rv_r <= rv_nxt;
		end
	end
	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	assign mem_addr = addr_r;
	assign mem_sel_n = sel_n_r;
	assign mem_we_n = we_n_r;
	assign mem_oe_n = oe_n_r;
	assign mem_dq_o = dq_o_r;
	assign mem_dq_oe = dq_oe_r;
	assign rsp_valid = rv_r;
	assign rsp_data = rd_r;
	// ----------------------------------------
	// Write pulse length
	// ----------------------------------------
	// Counts strobe-low samples; read by the checks only
	int wlen_r, wlen_nxt;
	always_comb begin
		wlen_nxt = mem_we_n ? 0 : wlen_r + 1;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			wlen_r <= 0;
		else
			wlen_r <= wlen_nxt;
	end
	// ----------------------------------------
	// Assertions: write side
	// ----------------------------------------
	sequence s_write_start;
		mem_we_n ##1 !mem_we_n;
	endsequence
	sequence s_write_end;
		!mem_we_n ##1 mem_we_n;
	endsequence
	// Zero address setup is allowed, so the address may move on the strobe edge
	a_addr_stable: assert property (@(posedge clk) disable iff (rst) // RULE8
		$changed(mem_addr) |-> $past(mem_we_n) || (&($past(mem_sel_n))))
		else $error("address moved mid write");
	a_addr_idle: assert property (@(posedge clk) disable iff (rst) // RULE8
		$changed(mem_addr) |-> $past(req_ready)) else $error("address moved while busy");
	a_write_pulse: assert property (@(posedge clk) disable iff (rst) // RULE9
		$rose(mem_we_n) |-> wlen_r >= WR_CYC) else $error("write pulse too short");
	a_write_len: assert property (@(posedge clk) disable iff (rst) // RULE9
		!mem_we_n |-> wlen_r < WR_CYC) else $error("write pulse too long");
	a_sel_in_write: assert property (@(posedge clk) disable iff (rst) // RULE10
		!mem_we_n |-> !(&mem_sel_n)) else $error("no lane during write");
	a_write_ends: assert property (@(posedge clk) disable iff (rst) // RULE10
		s_write_end |-> &mem_sel_n) else $error("select outlived strobe");
	a_write_setup: assert property (@(posedge clk) disable iff (rst) // RULE13
		s_write_start |-> mem_dq_oe && !(&mem_sel_n)) else $error("data not set up");
	a_addr_hold: assert property (@(posedge clk) disable iff (rst) // RULE12
		s_write_end |-> $stable(mem_addr)) else $error("address not held");
	a_data_hold: assert property (@(posedge clk) disable iff (rst) // RULE13
		s_write_end |-> mem_dq_oe && $stable(mem_dq_o)) else $error("data not held");
	a_oe_off_write: assert property (@(posedge clk) disable iff (rst) // RULE16
		!mem_we_n |-> mem_oe_n && mem_dq_oe) else $error("bus contention in write");
	// Both pins rise on one edge, so recovery lasts at least a full period
	a_idle_gap: assert property (@(posedge clk) disable iff (rst) // RULE12
		$rose(req_ready) |-> $past(mem_we_n) && $past(mem_oe_n)) else $error("no recovery gap");
	a_idle_no_drive: assert property (@(posedge clk) disable iff (rst) // RULE13
		req_ready |-> !mem_dq_oe) else $error("bus driven while idle");
	// ----------------------------------------
	// Assertions: read side
	// ----------------------------------------
	// Select and output enable stay low for the whole access
	a_read_we_high: assert property (@(posedge clk) disable iff (rst) // RULE1
		!mem_oe_n |-> mem_we_n) else $error("strobe low during read");
	a_read_lanes: assert property (@(posedge clk) disable iff (rst) // RULE18
		!mem_oe_n |-> !(&mem_sel_n)) else $error("no lane during read");
	a_read_addr: assert property (@(posedge clk) disable iff (rst) // RULE2
		!mem_oe_n |-> $stable(mem_addr) || $fell(mem_oe_n)) else $error("address moved in read");
	a_read_release: assert property (@(posedge clk) disable iff (rst) // RULE1
		$rose(mem_oe_n) |-> &mem_sel_n) else $error("select held after read");
	a_read_time: assert property (@(posedge clk) disable iff (rst) // RULE2
		$fell(mem_oe_n) |-> !mem_oe_n [*2] ##[1:300] rsp_valid) else $error("read too short");
	a_rsp_pulse: assert property (@(posedge clk) disable iff (rst) // RULE21
		rsp_valid |=> !rsp_valid) else $error("response longer than a cycle");
	a_no_drive_read: assert property (@(posedge clk) disable iff (rst) // RULE17
		!mem_oe_n |-> !mem_dq_oe) else $error("host drives during read");
	a_count_live: assert property (@(posedge clk) disable iff (rst) // RULE21
		st_r != ASR_IDLE |-> cnt_r != 8'h00) else $error("busy with zero count");
endmodule

//--- verif/asr_sram_model.sv
// Purpose: Behavioural 1M x 32 asynchronous SRAM module
// Assumes: Host pins change on its clock edges
// Notes: Floating lanes show a toggling pattern, never old data
module asr_sram_model (
	input wire logic [19:0] addr, // Address pins
	input wire logic [3:0] sel_n, // Byte lane selects
	input wire logic we_n, // Write strobe
	input wire logic oe_n, // Output enable
	input wire logic [31:0] dq_in, // Host data
	output logic [31:0] dq_out, // Data toward host
	output logic dq_en // High while driving
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [int];
	logic [31:0] junk = 32'h5A5A_A5A5;
	logic [31:0] word, rd_w;
	logic lz_ok, standby;
	wire sel_any = sel_n != 4'hF;
	always #7 junk = ~junk;
	// Drivers leave high impedance only 3 ns after a lane select falls
	always @(sel_any) lz_ok <= #3 sel_any;
	// Standby once deselected for the grade time, active again at once
	always @(sel_n) begin
		standby = 1'b0;
		if (&sel_n) begin
			#20;
			standby = &sel_n;
		end
	end
	// Settle first: pins switch together at the host edge
	always @(addr or sel_n or we_n or dq_in) #1 begin
		for (int i = 0; i < 4; i++)
			if (!we_n && !sel_n[i]) begin
				word = mem.exists(addr) ? mem[addr] : 32'h0;
				word[8*i +: 8] = dq_in[8*i +: 8];
				mem[addr] = word;
			end
	end
	// Old word stays on the bus until the new access completes
	always @(addr or sel_n or oe_n)
		#12 rd_w = mem.exists(addr) ? mem[addr] : ~junk;
	always @* begin
		dq_en = !oe_n && we_n && sel_any && lz_ok && !standby;
		for (int i = 0; i < 4; i++)
			dq_out[8*i +: 8] = (dq_en && !sel_n[i]) ? rd_w[8*i +: 8] : junk[8*i +: 8];
	end
endmodule

//--- verif/asr_host_tb_top.sv
// Purpose: Bench for the SRAM module host controller
// Assumes: Default cycle counts, 50 MHz clock
// Notes: Reads answer three cycles after being taken
module asr_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import asr_pkg::*;
	logic clk = 0, rst = 1, req_valid = 0, rsp_valid, req_ready, mem_we_n, mem_oe_n;
	logic mem_dq_oe, dq_en;
	asr_req_s req = '0;
	logic [31:0] rsp_data, mem_dq_o, mem_dq_i, dq_m;
	logic [19:0] mem_addr;
	logic [3:0] mem_sel_n;
	int n_mismatch = 0, n_checks = 0;
	always #10 clk = ~clk;
	assign mem_dq_i = mem_dq_oe ? mem_dq_o : dq_m;
	asr_host asr_host_inst (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_addr(mem_addr),
		.mem_sel_n(mem_sel_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_o(mem_dq_o),
		.mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i));
	asr_sram_model asr_sram_model_inst (.addr(mem_addr), .sel_n(mem_sel_n), .we_n(mem_we_n),
		.oe_n(mem_oe_n), .dq_in(mem_dq_o), .dq_out(dq_m), .dq_en(dq_en));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic issue(input logic wr, input logic [19:0] a, input logic [3:0] ln,
		input logic [31:0] d);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{wr, a, ln, d};
		@(negedge clk);
		for (int i = 0; i < 20 && !req_ready; i++)
			@(negedge clk);
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	task automatic wr(input logic [19:0] a, input logic [3:0] ln, input logic [31:0] d);
		issue(1'b1, a, ln, d);
		@(negedge clk);
		check({mem_we_n, mem_oe_n, mem_dq_oe, mem_sel_n}, {3'b011, ~ln});
		check(mem_dq_o, d);
		check(mem_addr, a);
		@(negedge clk);
		check({mem_we_n, mem_sel_n}, 5'h1F);
		check(mem_addr, a);
	endtask
	task automatic rd(input logic [19:0] a, input logic [3:0] ln, input logic [31:0] exp);
		int n;
		logic [31:0] m;
		m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
		issue(1'b0, a, ln, 32'h0);
		n = 1;
		@(negedge clk);
		check({mem_we_n, mem_oe_n, mem_dq_oe, mem_sel_n}, {3'b100, ~ln});
		while (!rsp_valid && n < 9) begin
			@(negedge clk);
			n++;
		end
		check(n, 4);
		check(rsp_data & m, exp & m);
	endtask
	// Host and module never drive the data bus together
	always @(negedge clk)
		if (!rst)
			check(mem_dq_oe & dq_en, 0);
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check({req_ready, mem_we_n, mem_oe_n, mem_dq_oe, mem_sel_n}, 8'hEF);
		check(mem_addr, 20'h0);
		wr(20'hFFFFF, 4'hF, 32'h1234_5678);
		rd(20'hFFFFF, 4'hF, 32'h1234_5678);
		wr(20'h00005, 4'hF, 32'h1122_3344);
		wr(20'h00005, 4'h5, 32'hAABB_CCDD);
		rd(20'h00005, 4'hF, 32'h11BB_33DD);
		rd(20'h00005, 4'h2, 32'h0000_3300);
		wrap_up();
	end
	// Whole sequence needs under a microsecond
	initial begin
		#100us;
		n_mismatch++;
		wrap_up();
	end
endmodule
